// ### mwsp_consts.svh
`ifndef MWSP_CONSTS_SVH
`define MWSP_CONSTS_SVH

// Opcodes.
`define MWSP_OP_READ        8'h03
`define MWSP_OP_FAST_READ   8'h0B
`define MWSP_OP_WRITE       8'h02
`define MWSP_OP_ENTER_DUAL  8'h3B
`define MWSP_OP_ENTER_QUAD  8'h38
`define MWSP_OP_RESET_WIDTH 8'hFF
`define MWSP_OP_STATUS_RD   8'h05
`define MWSP_OP_STATUS_WR   8'h01

// Dummy byte counts per opcode, single-bit mode and wider modes.
`define MWSP_DUMMY_READ_1   2'd0
`define MWSP_DUMMY_READ_N   2'd1
`define MWSP_DUMMY_FAST_1   2'd1
`define MWSP_DUMMY_FAST_N   2'd3
`define MWSP_DUMMY_STAT_1   2'd0
`define MWSP_DUMMY_STAT_N   2'd1

// Byte framing.
`define MWSP_ADDR_BYTES     2'd3
`define MWSP_LAST_CLK_1     3'd7
`define MWSP_LAST_CLK_2     3'd3
`define MWSP_LAST_CLK_4     3'd1
`define MWSP_ONES_CLOCKS    4'd8

// Status word: reset value and writable bits.
`define MWSP_STATUS_RESET   16'h4014
`define MWSP_STATUS_WMASK   16'hC11F
`define MWSP_PROT_HI        12
`define MWSP_PROT_LO        11

// Array address width of the documented density.
`define MWSP_MEM_AW         19

`endif

// ### mwsp_pkg.sv
package mwsp_pkg;

  // Bus width mode; the code doubles as the protocol field of the status word.
  typedef enum logic [1:0] {
    MWSP_SINGLE = 2'b00,
    MWSP_DUAL   = 2'b01,
    MWSP_QUAD   = 2'b10
  } mwsp_width_e;

  // Sequence phases, Gray coded along the usual path.
  typedef enum logic [2:0] {
    MWSP_CMD    = 3'b000,
    MWSP_ADDR   = 3'b001,
    MWSP_DUMMY  = 3'b011,
    MWSP_RDATA  = 3'b010,
    MWSP_WDATA  = 3'b110,
    MWSP_STWR   = 3'b111,
    MWSP_IGNORE = 3'b101
  } mwsp_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } mwsp_wr_event_s;

endpackage

// ### mwsp_serial_port.sv
`include "mwsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mwsp_serial_port #(
  parameter int MEM_AW = `MWSP_MEM_AW
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  input  wire logic [3:0]              data_line_in,
  output logic [3:0]                   data_line_out,
  output logic [3:0]                   data_line_oe,
  output mwsp_pkg::mwsp_width_e        width_mode,
  output logic                         wr_event_valid,
  output mwsp_pkg::mwsp_wr_event_s     wr_event
);
  import mwsp_pkg::*;

  if (MEM_AW < 1 || MEM_AW > 24)
  begin : g_check_aw
    $error("MEM_AW must lie between 1 and 24.");
  end

  // Power-on reset, held in the reference domain and used as the link's async reset.
  logic por_q;

  always_ff @(posedge ref_clk)
  begin
    por_q <= ~reset_n;
  end

  // Link-domain state.
  mwsp_width_e    mode_q;
  mwsp_state_e    state_q;
  logic [2:0]     cnt_q;
  logic [1:0]     byte_cnt_q;
  logic [1:0]     dummy_q;
  logic [7:0]     rx_q;
  logic [7:0]     cmd_q;
  logic [23:0]    addr_q;
  logic [3:0]     ones_q;
  logic [15:0]    status_q;
  logic           stat_lo_q;
  logic [7:0]     stat_hi_q;
  logic           wr_tgl_q;
  mwsp_wr_event_s wr_q;
  logic [3:0]     out_q;
  logic           oe_q;
  logic           pause_q;
  logic [7:0]     mem [0:(1 << MEM_AW) - 1];

  wire seq_rst = cs_n | por_q;
  wire single  = (mode_q == MWSP_SINGLE);
  wire dual    = (mode_q == MWSP_DUAL);
  wire quad    = (mode_q == MWSP_QUAD);

  // Pause is followed only while the clock is low, so it never changes mid-bit.
  always_latch
  begin
    if (seq_rst)
      pause_q = 1'b0;
    else if (!sck)
      pause_q = ~data_line_in[3] & ~quad;
  end

  // Byte framing per width.
  wire [2:0] last_clk = single ? `MWSP_LAST_CLK_1 :
                        dual   ? `MWSP_LAST_CLK_2 : `MWSP_LAST_CLK_4;
  wire       byte_done = (cnt_q == last_clk);
  wire [7:0] rx_next = single ? {rx_q[6:0], data_line_in[0]} :
                       dual   ? {rx_q[5:0], data_line_in[1:0]} :
                                {rx_q[3:0], data_line_in[3:0]};
  wire       lines_high = single ? data_line_in[0] :
                          dual   ? &data_line_in[1:0] : &data_line_in;
  // Counts clocks from select with every active line high; it saturates once any line drops.
  wire       rst_width = lines_high && (ones_q == `MWSP_ONES_CLOCKS - 4'd1);
  wire       run = ~pause_q;

  // Command decode.
  wire       cmd_done = run && (state_q == MWSP_CMD) && byte_done;
  wire       op_read  = (rx_next == `MWSP_OP_READ);
  wire       op_fast  = (rx_next == `MWSP_OP_FAST_READ);
  wire       op_write = (rx_next == `MWSP_OP_WRITE);
  wire       op_srd   = (rx_next == `MWSP_OP_STATUS_RD);
  wire       op_swr   = (rx_next == `MWSP_OP_STATUS_WR);
  wire [1:0] dummy_cmd = op_fast ? (single ? `MWSP_DUMMY_FAST_1 : `MWSP_DUMMY_FAST_N) :
                         op_read ? (single ? `MWSP_DUMMY_READ_1 : `MWSP_DUMMY_READ_N) :
                                   (single ? `MWSP_DUMMY_STAT_1 : `MWSP_DUMMY_STAT_N);
  wire       addr_last = (byte_cnt_q == `MWSP_ADDR_BYTES - 2'd1);
  wire       wr_en = run && (state_q == MWSP_WDATA) && byte_done;
  wire [MEM_AW-1:0] mem_idx = addr_q[MEM_AW-1:0];
  wire [15:0] status_rd = {status_q[15:13], mode_q, status_q[10:0]};
  // The high byte of a status write is held until its low byte arrives.
  wire [15:0] status_wr = (status_q & ~`MWSP_STATUS_WMASK) |
                          ({stat_hi_q, rx_next} & `MWSP_STATUS_WMASK);

  // Width mode keeps across frames; power-on or eight clocks with every active line high return it to single.
  always_ff @(posedge sck or posedge por_q)
  begin
    if (por_q)
      mode_q <= MWSP_SINGLE;
    else if (!cs_n && run && rst_width)
      mode_q <= MWSP_SINGLE;
    else if (!cs_n && cmd_done && single && rx_next == `MWSP_OP_ENTER_DUAL)
      mode_q <= MWSP_DUAL;
    else if (!cs_n && cmd_done && single && rx_next == `MWSP_OP_ENTER_QUAD)
      mode_q <= MWSP_QUAD;
  end

  // Status word and write event survive deselect.
  always_ff @(posedge sck or posedge por_q)
  begin
    if (por_q)
    begin
      status_q <= `MWSP_STATUS_RESET;
      wr_tgl_q <= 1'b0;
      wr_q     <= '0;
    end
    else if (!cs_n && run && state_q == MWSP_STWR && byte_done && stat_lo_q)
      status_q <= status_wr;
    else if (!cs_n && wr_en)
    begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_q     <= '{addr: addr_q, data: rx_next};
    end
  end

  // The array is not reset; bytes read before they are written are unknown.
  always_ff @(posedge sck)
  begin
    if (!cs_n && wr_en)
      mem[mem_idx] <= rx_next;
  end

  // Sequence logic, sampled on rising edges and cleared by deselect.
  always_ff @(posedge sck or posedge seq_rst)
  begin
    if (seq_rst)
    begin
      state_q    <= MWSP_CMD;
      cnt_q      <= 3'd0;
      byte_cnt_q <= 2'd0;
      dummy_q    <= 2'd0;
      rx_q       <= 8'h00;
      cmd_q      <= 8'h00;
      addr_q     <= 24'h00_0000;
      ones_q     <= 4'd0;
      stat_lo_q  <= 1'b0;
      stat_hi_q  <= 8'h00;
    end
    else if (run)
    begin
      rx_q   <= rx_next;
      cnt_q  <= byte_done ? 3'd0 : cnt_q + 3'd1;
      ones_q <= (!lines_high || ones_q == `MWSP_ONES_CLOCKS) ? `MWSP_ONES_CLOCKS : ones_q + 4'd1;
      if (byte_done)
      begin
        unique case (state_q)
          MWSP_CMD:
          begin
            cmd_q      <= rx_next;
            byte_cnt_q <= 2'd0;
            dummy_q    <= dummy_cmd;
            stat_lo_q  <= 1'b0;
            if (op_read || op_fast || op_write)
              state_q <= MWSP_ADDR;
            else if (op_srd)
              state_q <= (dummy_cmd == 2'd0) ? MWSP_RDATA : MWSP_DUMMY;
            else if (op_swr)
              state_q <= MWSP_STWR;
            else
              state_q <= MWSP_IGNORE;
          end
          MWSP_ADDR:
          begin
            addr_q     <= {addr_q[15:0], rx_next};
            byte_cnt_q <= byte_cnt_q + 2'd1;
            if (addr_last)
              state_q <= (cmd_q == `MWSP_OP_WRITE) ? MWSP_WDATA :
                         (dummy_q == 2'd0) ? MWSP_RDATA : MWSP_DUMMY;
          end
          MWSP_DUMMY:
          begin
            dummy_q <= dummy_q - 2'd1;
            if (dummy_q == 2'd1)
              state_q <= MWSP_RDATA;
          end
          MWSP_RDATA:
          begin
            stat_lo_q <= ~stat_lo_q;
            if (cmd_q != `MWSP_OP_STATUS_RD)
              addr_q <= addr_q + 24'h00_0001;
          end
          MWSP_WDATA:
            addr_q <= addr_q + 24'h00_0001;
          MWSP_STWR:
          begin
            stat_lo_q <= 1'b1;
            if (stat_lo_q)
              state_q <= MWSP_IGNORE;
            else
              stat_hi_q <= rx_next;
          end
          MWSP_IGNORE:
            state_q <= MWSP_IGNORE;
          default:
            state_q <= MWSP_IGNORE;
        endcase
      end
    end
  end

  // Transmit slice: the bits of this clock sit at the top after shifting.
  wire [7:0] tx_byte = (cmd_q == `MWSP_OP_STATUS_RD) ?
                       (stat_lo_q ? status_rd[7:0] : status_rd[15:8]) : mem[mem_idx];
  wire [2:0] tx_shift = single ? cnt_q : dual ? {cnt_q[1:0], 1'b0} : {cnt_q[0], 2'b00};
  wire [7:0] tx_sh = 8'(tx_byte << tx_shift);
  wire [3:0] tx_lines = single ? {2'b00, tx_sh[7], 1'b0} :
                        dual   ? {2'b00, tx_sh[7:6]} : tx_sh[7:4];
  wire [3:0] lane_mask = single ? 4'b0010 : dual ? 4'b0011 : 4'b1111;

  // Output bits change only on falling edges, and clear at once on deselect.
  always_ff @(negedge sck or posedge seq_rst)
  begin
    if (seq_rst)
    begin
      out_q <= 4'h0;
      oe_q  <= 1'b0;
    end
    else if (run)
    begin
      out_q <= tx_lines;
      oe_q  <= (state_q == MWSP_RDATA);
    end
  end

  wire hold_ok = quad | data_line_in[3];
  assign data_line_out = out_q;
  assign data_line_oe  = (oe_q && !cs_n && hold_ok) ? lane_mask : 4'b0000;

  // Crossings to the reference domain: Gray-safe mode level and a write toggle.
  // The event word must stand for three reference clocks to cross intact; full-rate quad writes outrun it.
  mwsp_width_e    mode_s1_q;
  mwsp_width_e    mode_s2_q;
  logic [2:0]     tgl_sync_q;
  logic           wr_valid_q;
  mwsp_wr_event_s wr_out_q;

  wire tgl_edge = tgl_sync_q[2] ^ tgl_sync_q[1];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mode_s1_q  <= MWSP_SINGLE;
      mode_s2_q  <= MWSP_SINGLE;
      tgl_sync_q <= 3'b000;
      wr_valid_q <= 1'b0;
      wr_out_q   <= '0;
    end
    else
    begin
      mode_s1_q  <= mode_q;
      mode_s2_q  <= mode_s1_q;
      tgl_sync_q <= {tgl_sync_q[1:0], wr_tgl_q};
      wr_valid_q <= tgl_edge;
      if (tgl_edge)
        wr_out_q <= wr_q;
    end
  end

  assign width_mode     = mode_s2_q;
  assign wr_event_valid = wr_valid_q;
  assign wr_event       = wr_out_q;

endmodule

`default_nettype wire

// ### mwsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_assertions
  import mwsp_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire logic                    sck,
  input wire logic                    cs_n,
  input wire logic [3:0]              data_line_in,
  input wire logic [3:0]              data_line_out,
  input wire logic [3:0]              data_line_oe,
  input wire mwsp_pkg::mwsp_width_e    width_mode,
  input wire logic                    wr_event_valid,
  input wire mwsp_pkg::mwsp_wr_event_s wr_event
);
  import mwsp_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  desel_float_a: assert property (cs_n |-> data_line_oe == 4'h0)
    else $error("output enabled while deselected");
  pause_float_a: assert property (!data_line_in[3] && width_mode != MWSP_QUAD |-> data_line_oe == 4'h0)
    else $error("output enabled while paused");
  reset_single_a: assert property ($rose(reset_n) |-> width_mode == MWSP_SINGLE && !wr_event_valid)
    else $error("not single mode after reset");
  mode_step_a: assert property ($changed(width_mode) |-> width_mode == MWSP_SINGLE || $past(width_mode) == MWSP_SINGLE)
    else $error("direct change between wide modes");
  single_lane_a: assert property (width_mode == MWSP_SINGLE |-> data_line_oe inside {4'h0, 4'h2})
    else $error("single mode drives a wrong lane");
  dual_lane_a: assert property (width_mode == MWSP_DUAL |-> data_line_oe inside {4'h0, 4'h3})
    else $error("dual mode drives a wrong lane");
  quad_lane_a: assert property (width_mode == MWSP_QUAD |-> data_line_oe inside {4'h0, 4'hF})
    else $error("quad mode drives a wrong lane");
  event_pulse_a: assert property (wr_event_valid |=> !wr_event_valid)
    else $error("write event longer than one cycle");
  event_hold_a: assert property (!$rose(wr_event_valid) |-> $stable(wr_event))
    else $error("write event changed without a pulse");
endmodule

bind mwsp_serial_port mwsp_assertions u_mwsp_assertions (
  .ref_clk(ref_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
  .data_line_in(data_line_in), .data_line_out(data_line_out), .data_line_oe(data_line_oe),
  .width_mode(width_mode), .wr_event_valid(wr_event_valid), .wr_event(wr_event)
);
`default_nettype wire

// ### mwsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_host_model (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      host_d,
  input  wire logic [3:0] line
);
  int   w      = 1;
  logic cpol   = 1'b0;
  logic hold_n = 1'b1;
  initial
  begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    host_d = 4'hF;
  end
  task automatic set_cpol(input logic v);
    cpol = v;
    sck  = v;
  endtask
  task automatic sel();
    #3 cs_n = 1'b0;
    #3;
  endtask
  // The clock returns to its idle level before deselect and stands there between frames.
  task automatic desel();
    sck = cpol;
    #3 cs_n = 1'b1;
    #6;
  endtask
  // Released lanes toggle every clock so that a stale level never passes for data.
  task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    logic [3:0] nxt;
    rx = 8'h00;
    repeat (8 / w)
    begin
      sck = 1'b0;
      nxt = drv ? host_d : ~host_d;
      if (drv)
        for (int i = 0; i < w; i++)
          nxt[w - 1 - i] = tx[7 - i];
      if (w < 4)
        nxt[3] = hold_n;
      host_d = nxt;
      tx = tx << w;
      #3 rx = (rx << w) | ((w == 1) ? {7'h00, line[1]} : {4'h0, line & ((4'h1 << w) - 4'h1)});
      sck = 1'b1;
      #3;
    end
  endtask
  // Pauses with the clock low; while paused it runs clocks that must be ignored.
  task automatic hold(input logic v);
    sck = 1'b0;
    #1 hold_n = v;
    host_d[3] = v;
    #2;
    if (!v)
      repeat (3)
      begin
        host_d[0] = ~host_d[0];
        #3 sck = 1'b1;
        #3 sck = 1'b0;
      end
  endtask
endmodule
`default_nettype wire

// ### mwsp_serial_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_serial_port_tb_top;
  import mwsp_pkg::*;
  logic           ref_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           sck;
  logic           cs_n;
  logic [3:0]     host_d;
  wire logic [3:0] dl_in;
  logic [3:0]     dl_out;
  logic [3:0]     dl_oe;
  mwsp_width_e    width_mode;
  logic           wr_event_valid;
  mwsp_wr_event_s wr_event;
  logic [7:0]     rx;
  int             mismatches  = 0;
  int             comparisons = 0;
  int             cycles      = 0;
  int             events      = 0;

  always #2.5 ref_clk = ~ref_clk;
  assign dl_in = (dl_oe & dl_out) | (~dl_oe & host_d);
  mwsp_serial_port #(.MEM_AW(8)) u_mwsp_serial_port (
    .ref_clk(ref_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .data_line_in(dl_in),
    .data_line_out(dl_out), .data_line_oe(dl_oe), .width_mode(width_mode),
    .wr_event_valid(wr_event_valid), .wr_event(wr_event));
  mwsp_host_model u_mwsp_host_model (.sck(sck), .cs_n(cs_n), .host_d(host_d), .line(dl_in));

  always @(posedge ref_clk)
  begin
    cycles++;
    if (wr_event_valid === 1'b1)
      events++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int na, input int nd);
    u_mwsp_host_model.sel();
    u_mwsp_host_model.xfer(op, 1'b1, rx);
    repeat (na)
    begin
      u_mwsp_host_model.xfer(a[23:16], 1'b1, rx);
      a = a << 8;
    end
    repeat (nd)
      u_mwsp_host_model.xfer(8'h00, 1'b1, rx);
  endtask
  // Sends the opcode once per active lane, filling eight clocks in the current width.
  task automatic mode(input logic [7:0] op, input mwsp_width_e m, input int w);
    u_mwsp_host_model.sel();
    repeat (u_mwsp_host_model.w)
      u_mwsp_host_model.xfer(op, 1'b1, rx);
    u_mwsp_host_model.desel();
    repeat (8) @(posedge ref_clk);
    #1;
    u_mwsp_host_model.w = w;
    check("width_mode", width_mode, m);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int na, input int nd,
                    input logic [7:0] d, input int n);
    hdr(op, a, na, nd);
    for (int i = 0; i < n; i++)
    begin
      u_mwsp_host_model.xfer(8'h00, 1'b0, rx);
      check("read byte", rx, d + 8'(i));
    end
    u_mwsp_host_model.desel();
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d, input int n);
    int k;
    hdr(8'h02, a, 3, 0);
    for (int i = 0; i < n; i++)
    begin
      u_mwsp_host_model.xfer(d + 8'(i), 1'b1, rx);
      k = 0;
      while (wr_event_valid !== 1'b1 && k < 20)
      begin
        @(posedge ref_clk);
        #1 k++;
      end
      check("write event", {wr_event_valid, wr_event.addr[7:0], wr_event.data}, {1'b1, a[7:0] + 8'(i), d + 8'(i)});
    end
    u_mwsp_host_model.desel();
  endtask
  task automatic t_abort();
    int e;
    e = events;
    hdr(8'h02, 24'h00_0012, 3, 0);
    u_mwsp_host_model.w = 2;
    u_mwsp_host_model.xfer(8'hFF, 1'b1, rx);
    u_mwsp_host_model.w = 1;
    u_mwsp_host_model.desel();
    repeat (10) @(posedge ref_clk);
    #1;
    check("abort events", events, e);
    rd(8'h03, 24'h00_0012, 3, 0, 8'h3C, 1);
    $display("test abort done");
  endtask
  task automatic t_pause();
    hdr(8'h03, 24'h00_0013, 3, 0);
    u_mwsp_host_model.hold(1'b0);
    check("paused enable", dl_oe, 4'h0);
    u_mwsp_host_model.hold(1'b1);
    check("resumed enable", dl_oe, 4'h2);
    u_mwsp_host_model.xfer(8'h00, 1'b0, rx);
    check("paused read", rx, 8'h3D);
    u_mwsp_host_model.desel();
    hdr(8'h03, 24'h00_0013, 3, 0);
    u_mwsp_host_model.hold(1'b0);
    u_mwsp_host_model.desel();
    u_mwsp_host_model.hold(1'b1);
    check("deselect in pause", dl_oe, 4'h0);
    rd(8'h03, 24'h00_0012, 3, 0, 8'h3C, 2);
    $display("test pause done");
  endtask
  // Writes both status bytes plus one extra that must be ignored, then reads high and low back.
  task automatic t_status();
    hdr(8'h01, 24'h00_0000, 0, 0);
    u_mwsp_host_model.xfer(8'hFF, 1'b1, rx);
    u_mwsp_host_model.xfer(8'hEA, 1'b1, rx);
    u_mwsp_host_model.xfer(8'h00, 1'b1, rx);
    u_mwsp_host_model.desel();
    hdr(8'h05, 24'h00_0000, 0, 0);
    u_mwsp_host_model.xfer(8'h00, 1'b0, rx);
    check("status high", rx, 8'hC1);
    u_mwsp_host_model.xfer(8'h00, 1'b0, rx);
    check("status low", rx, 8'h0A);
    u_mwsp_host_model.desel();
    $display("test status done");
  endtask
  task automatic t_single();
    rd(8'h05, 24'h00_0000, 0, 0, 8'h40, 1);
    wr(24'hA5_5A12, 8'h3C, 2);
    rd(8'h03, 24'h00_0012, 3, 0, 8'h3C, 2);
    rd(8'h0B, 24'hFF_FF12, 3, 1, 8'h3C, 2);
    $display("test single done");
  endtask
  // The second entry command, the other wide opcode, must be refused.
  task automatic t_wide(input logic [7:0] op, input mwsp_width_e m, input int w, input logic [7:0] d,
                        input logic [7:0] st);
    mode(op, m, w);
    mode(op ^ 8'h03, m, w);
    wr(24'h00_0040, d, 2);
    rd(8'h0B, 24'h00_0040, 3, 3, d, 2);
    rd(8'h03, 24'h00_0040, 3, 1, d, 1);
    rd(8'h05, 24'h00_0000, 0, 1, st, 1);
    mode(8'hFF, MWSP_SINGLE, 1);
    $display("test wide done");
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    u_mwsp_host_model.sel();
    u_mwsp_host_model.desel();
    check("reset mode", width_mode, MWSP_SINGLE);
    t_single();
    t_abort();
    t_pause();
    t_wide(8'h3B, MWSP_DUAL, 2, 8'h81, 8'h48);
    u_mwsp_host_model.set_cpol(1'b1);
    t_wide(8'h38, MWSP_QUAD, 4, 8'hE7, 8'h50);
    t_status();
    results();
  end
endmodule
`default_nettype wire
